// File: adc_conversion_rate_sequencer_bench.sv
// self-checking bench of the conversion rate sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_rate_sequencer_bench;
	import adcseq_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, power_en;
	logic conv_busy, conv_start, conv_end, done;
	logic [1:0] bresp, rresp, conv_ch;
	logic [31:0] rdata;
	logic [3:0] sh_sample, mux_sel;
	int n_fail = 0, checks = 0, cyc = 0, model_err;
	int st[$], sch[$], en[$], dn[$];

	adcseq_top i_dut (.CLK_I(clk), .RST_N_I(rst_n),
		.AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
		.AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata),
		.AXI_WSTRB_I(4'hf), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
		.AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
		.AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid),
		.AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
		.AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready), .EXT_TRIG_I(1'b0),
		.POWER_EN_O(power_en), .SH_SAMPLE_O(sh_sample),
		.MUX_SEL_O(mux_sel), .CONV_CH_O(conv_ch), .CONV_BUSY_O(conv_busy),
		.CONV_START_O(conv_start), .CONV_END_O(conv_end), .DONE_O(done));

	adcseq_sh_model i_sh (.clk_i(clk), .sh_sample_i(sh_sample),
		.conv_start_i(conv_start), .conv_ch_i(conv_ch), .err_o(model_err));

	// 10 MHz clock
	initial begin
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (n_fail == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic bail;
		n_fail++;
		$display("unexpected at %0t: wait ran out", $time);
		tally_and_finish();
	endtask

	// log conversion events; starts never closer than the rate limit
	always @(posedge clk) begin
		cyc++;
		if (conv_start) begin
			if (st.size() > 0) chk(32'(cyc - st[$] >= 10), 1);
			st.push_back(cyc);
			sch.push_back(conv_ch);
		end
		if (conv_end) en.push_back(cyc);
		if (done) dn.push_back(cyc);
	end

	// ready is read at the falling edge, the handshake lands on the rising
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ta, tw, ra, rw, gb;
		logic [1:0] r;
		int n;
		ta = 0;
		tw = 0;
		gb = 0;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!gb) begin
			@(negedge clk);
			ra = awready && !ta;
			rw = wready && !tw;
			gb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ra) awvalid <= 1'b0;
			if (rw) wvalid <= 1'b0;
			ta = ta | ra;
			tw = tw | rw;
			if (++n > 60) bail();
		end
		// bready stays high so a following call never toggles it
		chk(32'(r), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ta, ra, gr;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		ta = 0;
		gr = 0;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!gr) begin
			@(negedge clk);
			ra = arready && !ta;
			gr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ra) arvalid <= 1'b0;
			ta = ta | ra;
			if (++n > 60) bail();
		end
		// rready stays high so a following call never toggles it
		chk(d, ed);
		chk(32'(r), 32'(er));
	endtask

	task automatic wait_starts(input int k);
		int n;
		n = 0;
		while (st.size() < k) begin
			@(posedge clk);
			if (++n > 3000) bail();
		end
	endtask

	// configure, clear the logs, then switch on
	task automatic run(input logic [31:0] c1, c2, c3);
		wr(OFS_CTRL_THREE, c3, RESP_OKAY);
		wr(OFS_CTRL_TWO, c2, RESP_OKAY);
		wr(OFS_MUX_SEL, 32'h0000_0005, RESP_OKAY);
		st.delete();
		sch.delete();
		en.delete();
		dn.delete();
		// power up first and let the front end settle before sampling
		wr(OFS_CTRL_ONE, 32'h0000_8000, RESP_OKAY);
		repeat (4) @(posedge clk);
		wr(OFS_CTRL_ONE, c1, RESP_OKAY);
	endtask

	task automatic stop;
		wr(OFS_CTRL_ONE, 32'h0000_0000, RESP_OKAY);
		repeat (3) @(posedge clk);
	endtask

	task automatic s_reset;
		rd(OFS_CTRL_ONE, 32'h0000_0000, RESP_OKAY);
		rd(OFS_CTRL_THREE, 32'h0000_0000, RESP_OKAY);
		wr(OFS_STATUS, 32'hffff_ffff, RESP_OKAY);
		rd(OFS_STATUS, {20'h0_0000, RATE_GAP_MAX, 8'h00}, RESP_OKAY);
		rd(8'h14, 32'h0000_0000, RESP_SLVERR);
		wr(8'h18, 32'hffff_ffff, RESP_SLVERR);
		chk(32'(power_en), 0);
	endtask

	// one channel, period is (12 + sample) conversion clocks
	task automatic s_rate;
		logic [5:0] dv [4] = '{6'h01, 6'h05, 6'h00, 6'h01};
		logic [4:0] at [4] = '{5'h02, 5'h02, 5'h01, 5'h00};
		int per [4] = '{14, 42, 13, 13};
		int td [4] = '{1, 3, 1, 1};
		for (int i = 0; i < 4; i++) begin
			run(32'h0000_80e4, 32'h0000_0000,
				{19'h0, at[i], 2'h0, dv[i]});
			wait_starts(4);
			chk(st[3] - st[2], per[i]);
			if (td[i] == 1) chk(en[2] - st[2], 12);
			chk(dn.size(), en.size());
			stop();
		end
	endtask

	// two channels on one pin, sequential sampling
	task automatic s_seq2;
		run(32'h0000_80e4, 32'h0000_0104, 32'h0000_0201);
		wait_starts(5);
		for (int i = 0; i < 4; i++) chk(sch[i], i % 2);
		chk(dn.size(), 2);
		chk(32'(mux_sel), 5);
		stop();
	endtask

	// both four-channel codes, simultaneous sampling
	task automatic s_sim4;
		for (int c = 2; c < 4; c++) begin
			run(32'h0000_80ec, {22'h0, 2'(c), 8'h0c}, 32'h0000_0201);
			wait_starts(4);
			for (int i = 0; i < 4; i++) chk(sch[i], i);
			stop();
		end
	endtask

	// switching off mid-conversion aborts and idles everything
	task automatic s_off;
		run(32'h0000_80e4, 32'h0000_0000, 32'h0000_0201);
		wait_starts(1);
		wr(OFS_CTRL_ONE, 32'h0000_0000, RESP_OKAY);
		@(negedge clk);
		chk(32'(power_en), 0);
		chk(32'(conv_busy), 0);
		chk(32'(sh_sample), 0);
		repeat (40) @(posedge clk);
		chk(st.size(), 1);
		chk(en.size(), 0);
	endtask

	// reset, then each scenario in turn
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		s_reset();
		s_rate();
		s_seq2();
		s_sim4();
		s_off();
		chk(model_err, 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// File: adcseq_pkg.sv
// constants, types and helpers of the conversion rate sequencer
`default_nettype none
package adcseq_pkg;
	// clock and rate limit
	localparam int CLK_PERIOD_NS = 100;
	localparam int MIN_CONV_PERIOD_NS = 1000;
	localparam int RATE_CYC = (MIN_CONV_PERIOD_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam logic [3:0] RATE_GAP_MIN = 4'(RATE_CYC - 1);
	localparam logic [3:0] RATE_GAP_MAX = 4'hf;
	// conversion timing in conversion clock periods
	localparam logic [4:0] CONV_TADS = 5'h0c;
	localparam logic [4:0] MIN_SAMPLE_TADS = 5'h01;
	localparam logic [4:0] CNT_MAX = 5'h1f;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
	localparam logic [7:0] OFS_MUX_SEL = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	// field positions in the control registers
	localparam int B_DONE = 0;
	localparam int B_ACQ = 1;
	localparam int B_AUTO_SAMPLE_ENABLE = 2;
	localparam int B_SIMULTANEOUS_SAMPLE_SELECT = 3;
	localparam int B_TRIG = 5;
	localparam int B_ON = 15;
	localparam int B_SPI = 2;
	localparam int B_CHCNT = 8;
	localparam int B_DIV = 0;
	localparam int B_AST = 8;
	// reset values
	localparam logic [5:0] DIV_RST = 6'h00;
	localparam logic [4:0] AST_RST = 5'h00;
	// trigger source codes
	localparam logic [2:0] TRIG_MANUAL = 3'h0;
	localparam logic [2:0] TRIG_AUTO = 3'h7;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SAMPLE = 2'h1,
		ST_CONVERT = 2'h3
	} adcseq_state_e;

	// index of the last enabled sample/hold channel
	function automatic logic [1:0] adcseq_last_ch(input logic [1:0] code);
		adcseq_last_ch = (code == 2'h0) ? 2'h0 : (code == 2'h1) ? 2'h1 : 2'h3;
	endfunction
endpackage
`default_nettype wire

// File: adcseq_sh_model.sv
// sample/hold bank model that checks acquisition before each conversion
`timescale 1ns/1ps
`default_nettype none
module adcseq_sh_model (
	// clock and front end control
	input wire logic clk_i,
	input wire logic [3:0] sh_sample_i,
	input wire logic conv_start_i,
	input wire logic [1:0] conv_ch_i,
	// conversions of a channel that had not acquired since its last conversion
	output int err_o
);
	int acq [4];

	// a held channel must have acquired for some time first
	always @(posedge clk_i) begin
		if (conv_start_i) begin
			if (acq[conv_ch_i] == 0) err_o++;
			acq[conv_ch_i] = 0;
		end
		for (int k = 0; k < 4; k++) begin
			if (sh_sample_i[k]) acq[k]++;
		end
	end
endmodule
`default_nettype wire

// File: adcseq_tad_div.sv
// conversion clock divider producing one-cycle enable pulses
`timescale 1ns/1ps
`default_nettype none
module adcseq_tad_div
	import adcseq_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// enable link
	adcseq_tad_if.src tad
);
	typedef struct packed {
		logic [6:0] acc;
		logic tick;
	} adcseq_div_s;

	adcseq_div_s s_q;
	adcseq_div_s s_d;
	logic [6:0] lim;
	logic [6:0] sum;

	// half-cycle accumulator: adds two half periods per clock
	always_comb begin
		s_d = s_q;
		lim = {1'b0, tad.divide} + 7'h01;
		sum = s_q.acc + 7'h02;
		s_d.tick = 1'b0;
		if (!tad.run) begin
			s_d.acc = 7'h00;
		end else if (sum >= lim) begin
			s_d.tick = 1'b1;
			s_d.acc = sum - lim;
			// below one clock the period is clamped to one clock
			if (s_d.acc >= lim) begin
				s_d.acc = 7'h00;
			end
		end else begin
			s_d.acc = sum;
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tad.tick = s_q.tick;

	// divide value five gives one pulse every three clocks
	div_period_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(s_q.tick && tad.run && $stable(tad.run) && tad.divide == 6'h05 &&
		$stable(tad.divide)) |=> (!s_q.tick || !tad.run || tad.divide != 6'h05)
		[*2] ##1 (s_q.tick || !tad.run || tad.divide != 6'h05))
		else $error("conversion clock period wrong");
endmodule
`default_nettype wire

// File: adcseq_tad_if.sv
// conversion clock enable link between sequencer and divider
`timescale 1ns/1ps
`default_nettype none
interface adcseq_tad_if;
	logic [5:0] divide;
	logic run;
	logic tick;
	modport src (input divide, input run, output tick);
	modport snk (output divide, output run, input tick);
endinterface
`default_nettype wire

// File: adcseq_top.sv
// conversion rate sequencer with its register slave
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adcseq_top
	import adcseq_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// register bus write channels
	input wire logic [7:0] AXI_AWADDR_I,
	input wire logic AXI_AWVALID_I,
	output logic AXI_AWREADY_O,
	input wire logic [31:0] AXI_WDATA_I,
	input wire logic [3:0] AXI_WSTRB_I,
	input wire logic AXI_WVALID_I,
	output logic AXI_WREADY_O,
	output logic [1:0] AXI_BRESP_O,
	output logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	// register bus read channels
	input wire logic [7:0] AXI_ARADDR_I,
	input wire logic AXI_ARVALID_I,
	output logic AXI_ARREADY_O,
	output logic [31:0] AXI_RDATA_O,
	output logic [1:0] AXI_RRESP_O,
	output logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	// external conversion trigger
	input wire logic EXT_TRIG_I,
	// analog front end control
	output logic POWER_EN_O,
	output logic [3:0] SH_SAMPLE_O,
	output logic [3:0] MUX_SEL_O,
	output logic [1:0] CONV_CH_O,
	output logic CONV_BUSY_O,
	output logic CONV_START_O,
	output logic CONV_END_O,
	output logic DONE_O
);
	typedef struct packed {
		adcseq_state_e st;
		logic on;
		logic simultaneous_sample_select;
		logic auto_sample_enable;
		logic acq;
		logic done;
		logic [2:0] trig;
		logic [1:0] chcnt;
		logic [3:0] spi;
		logic [4:0] ast;
		logic [5:0] div;
		logic [3:0] mux;
		logic pend;
		logic [4:0] cnt;
		logic [1:0] cur;
		logic [3:0] seq;
		logic [3:0] gap;
		logic aw_h;
		logic w_h;
		logic [7:0] awa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
		logic start_p;
		logic end_p;
		logic done_p;
		logic [3:0] sh;
	} adcseq_top_s;

	adcseq_top_s s;
	adcseq_top_s n;
	adcseq_tad_if tad ();

	adcseq_tad_div u_div (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.tad(tad)
	);

	// register view, shared by reads and by masked writes
	function automatic logic [31:0] reg_word(input adcseq_top_s r,
		input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (a)
			OFS_CTRL_ONE: begin
				w[B_ON] = r.on;
				w[B_TRIG +: 3] = r.trig;
				w[B_SIMULTANEOUS_SAMPLE_SELECT] = r.simultaneous_sample_select;
				w[B_AUTO_SAMPLE_ENABLE] = r.auto_sample_enable;
				w[B_ACQ] = r.acq;
				w[B_DONE] = r.done;
			end
			OFS_CTRL_TWO: begin
				w[B_CHCNT +: 2] = r.chcnt;
				w[B_SPI +: 4] = r.spi;
			end
			OFS_CTRL_THREE: begin
				w[B_AST +: 5] = r.ast;
				w[B_DIV +: 6] = r.div;
			end
			OFS_MUX_SEL: w[3:0] = r.mux;
			OFS_STATUS: w[11:0] = {r.gap, r.seq, r.cur, r.st};
			default: w = 32'h0000_0000;
		endcase
		reg_word = w;
	endfunction

	// true for the five mapped offsets
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == OFS_CTRL_ONE) || (a == OFS_CTRL_TWO) ||
			(a == OFS_CTRL_THREE) || (a == OFS_MUX_SEL) || (a == OFS_STATUS);
	endfunction

	logic aw_take;
	logic w_take;
	logic wr_go;
	logic mux_wr;
	logic fire;
	logic [31:0] mask;
	logic [31:0] wv;
	logic [1:0] last;
	logic [4:0] need;
	logic [5:0] smp;

	// bus slave, register writes, then the sequencer
	always_comb begin
		n = s;
		aw_take = AXI_AWVALID_I && !s.aw_h && !s.bv;
		w_take = AXI_WVALID_I && !s.w_h && !s.bv;
		wr_go = s.aw_h && s.w_h;
		mux_wr = 1'b0;
		fire = 1'b0;
		mask = {{8{s.ws[3]}}, {8{s.ws[2]}}, {8{s.ws[1]}}, {8{s.ws[0]}}};
		wv = (reg_word(s, s.awa) & ~mask) | (s.wd & mask);
		last = adcseq_last_ch(s.chcnt);
		need = (s.ast < MIN_SAMPLE_TADS) ? MIN_SAMPLE_TADS : s.ast;
		// periods sampled, the one ending now included
		smp = {1'b0, s.cnt} + {5'h00, tad.tick};
		n.start_p = 1'b0;
		n.end_p = 1'b0;
		n.done_p = 1'b0;
		// address and data may arrive in either order
		if (aw_take) begin
			n.aw_h = 1'b1;
			n.awa = AXI_AWADDR_I;
		end
		if (w_take) begin
			n.w_h = 1'b1;
			n.wd = AXI_WDATA_I;
			n.ws = AXI_WSTRB_I;
		end
		if (s.bv && AXI_BREADY_I) begin
			n.bv = 1'b0;
		end
		if (wr_go) begin
			n.aw_h = 1'b0;
			n.w_h = 1'b0;
			n.bv = 1'b1;
			n.br = is_mapped(s.awa) ? RESP_OKAY : RESP_SLVERR;
			unique case (s.awa)
				OFS_CTRL_ONE: begin
					n.on = wv[B_ON];
					n.trig = wv[B_TRIG +: 3];
					n.simultaneous_sample_select = wv[B_SIMULTANEOUS_SAMPLE_SELECT];
					n.auto_sample_enable = wv[B_AUTO_SAMPLE_ENABLE];
					n.acq = wv[B_ACQ];
					// done only clears, hardware alone sets it
					n.done = s.done & wv[B_DONE];
				end
				OFS_CTRL_TWO: begin
					n.chcnt = wv[B_CHCNT +: 2];
					n.spi = wv[B_SPI +: 4];
				end
				OFS_CTRL_THREE: begin
					n.ast = wv[B_AST +: 5];
					n.div = wv[B_DIV +: 6];
				end
				OFS_MUX_SEL: begin
					n.mux = wv[3:0];
					mux_wr = 1'b1;
				end
				default: n.br = n.br;
			endcase
		end
		// read channel answers one cycle after the address is taken
		if (s.rv && AXI_RREADY_I) begin
			n.rv = 1'b0;
		end
		if (AXI_ARVALID_I && !s.rv) begin
			n.rv = 1'b1;
			n.rd = reg_word(s, AXI_ARADDR_I);
			n.rr = is_mapped(AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
		end
		// spacing guard for the aggregate rate
		if (s.gap != RATE_GAP_MAX) begin
			n.gap = s.gap + 4'h1;
		end
		if (!n.on) begin
			// off mode wins over any pending auto start
			n.st = ST_IDLE;
			n.acq = 1'b0;
			n.pend = 1'b0;
			n.cnt = 5'h00;
			n.cur = 2'h0;
			n.seq = 4'h0;
		end else begin
			unique case (s.st)
				ST_IDLE: begin
					if (n.acq || s.auto_sample_enable) begin
						n.st = ST_SAMPLE;
						n.acq = 1'b1;
						n.cnt = 5'h00;
						n.pend = 1'b0;
					end
				end
				ST_SAMPLE: begin
					if (tad.tick && s.cnt != CNT_MAX) begin
						n.cnt = s.cnt + 5'h01;
					end
					// software clearing the bit is the manual trigger
					if (s.trig == TRIG_MANUAL && s.acq && !n.acq) begin
						n.pend = 1'b1;
					end
					if (s.trig != TRIG_MANUAL && s.trig != TRIG_AUTO &&
						EXT_TRIG_I) begin
						n.pend = 1'b1;
					end
					if (s.trig == TRIG_AUTO) begin
						// start on the tick that closes the last period
						fire = (smp >= {1'b0, need});
					end else begin
						// an early trigger waits for one sampled period
						fire = s.pend &&
							(smp >= {1'b0, MIN_SAMPLE_TADS});
					end
					// rate guard keeps starts at least a microsecond apart
					fire = fire && (s.gap >= RATE_GAP_MIN);
					if (mux_wr) begin
						// new input: the sample interval starts again
						n.cnt = 5'h00;
					end else if (fire) begin
						n.st = ST_CONVERT;
						n.cnt = 5'h00;
						n.pend = 1'b0;
						n.acq = 1'b0;
						n.gap = 4'h0;
						n.start_p = 1'b1;
					end
				end
				ST_CONVERT: begin
					if (tad.tick) begin
						n.cnt = s.cnt + 5'h01;
						if (s.cnt == CONV_TADS - 5'h01) begin
							n.cnt = 5'h00;
							n.end_p = 1'b1;
							if (s.seq == s.spi) begin
								n.done = 1'b1;
								n.done_p = 1'b1;
								n.seq = 4'h0;
							end else begin
								n.seq = s.seq + 4'h1;
							end
							// both modes rotate the converted channel, wrapping after the last
							n.cur = (s.cur == last) ? 2'h0 : s.cur + 2'h1;
							if (s.simultaneous_sample_select && s.cur != last) begin
								n.st = ST_CONVERT;
								n.start_p = 1'b1;
								n.gap = 4'h0;
							end else if (s.auto_sample_enable) begin
								n.st = ST_SAMPLE;
								n.acq = 1'b1;
							end else begin
								n.st = ST_IDLE;
							end
						end
					end
				end
				default: n.st = ST_IDLE;
			endcase
		end
		// enabled channels acquire while sampling; in sequential mode all but the converting one also acquire during conversion
		for (int k = 0; k < 4; k++) begin
			if (!n.on || n.st == ST_IDLE || 2'(k) > last) begin
				n.sh[k] = 1'b0;
			end else if (s.simultaneous_sample_select) begin
				n.sh[k] = (n.st == ST_SAMPLE);
			end else begin
				n.sh[k] = !(n.st == ST_CONVERT && n.cur == 2'(k));
			end
		end
	end

	// state register
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.div <= DIV_RST;
			s.ast <= AST_RST;
			s.gap <= RATE_GAP_MAX;
		end else begin
			s <= n;
		end
	end

	// divider link: stopped while off to save switching
	assign tad.divide = s.div;
	assign tad.run = s.on;

	// outputs
	assign AXI_AWREADY_O = !s.aw_h && !s.bv;
	assign AXI_WREADY_O = !s.w_h && !s.bv;
	assign AXI_BVALID_O = s.bv;
	assign AXI_BRESP_O = s.br;
	assign AXI_ARREADY_O = !s.rv;
	assign AXI_RVALID_O = s.rv;
	assign AXI_RDATA_O = s.rd;
	assign AXI_RRESP_O = s.rr;
	assign POWER_EN_O = s.on;
	assign SH_SAMPLE_O = s.sh;
	assign MUX_SEL_O = s.mux;
	assign CONV_CH_O = s.cur;
	assign CONV_BUSY_O = (s.st == ST_CONVERT);
	assign CONV_START_O = s.start_p;
	assign CONV_END_O = s.end_p;
	assign DONE_O = s.done_p;

	power_off_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!s.on |-> (s.st == ST_IDLE && s.sh == 4'h0 && !s.start_p))
		else $error("converter active while off");

	conv_len_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s.end_p |-> ($past(s.cnt) == CONV_TADS - 5'h01 && $past(tad.tick)))
		else $error("conversion not twelve periods");

	min_sample_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(s.start_p && $past(s.st) == ST_SAMPLE) |->
		$past(smp) >= {1'b0, MIN_SAMPLE_TADS})
		else $error("conversion began without one sampled period");

	auto_time_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(s.start_p && $past(s.st) == ST_SAMPLE && $past(s.trig) == TRIG_AUTO)
		|-> ($past(smp) >= {1'b0, $past(s.ast)} && $past(smp) != 6'h00))
		else $error("auto start before programmed sample time");

	rate_gap_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s.start_p |-> $past(s.gap) >= RATE_GAP_MIN)
		else $error("conversions closer than the rate limit");

	done_count_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s.done_p |-> (s.end_p && s.done && $past(s.seq) == $past(s.spi)))
		else $error("done raised at wrong conversion count");

	alt_ch_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(s.end_p && !$past(s.simultaneous_sample_select) && $past(s.chcnt) == 2'h1) |->
		s.cur != $past(s.cur))
		else $error("held channel did not alternate");

	auto_restart_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(s.end_p && $past(s.auto_sample_enable) && $past(s.on) && s.on && !CONV_BUSY_O)
		|-> (s.st == ST_SAMPLE && s.acq))
		else $error("acquisition did not restart");

	mux_restart_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		($past(s.st) == ST_SAMPLE && s.st == ST_SAMPLE && $past(wr_go) &&
		$past(s.awa) == OFS_MUX_SEL && $past(s.on)) |-> s.cnt == 5'h00)
		else $error("sample interval not restarted on input change");

	pingpong_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(CONV_BUSY_O && !s.simultaneous_sample_select && s.chcnt != 2'h0) |->
		(!s.sh[s.cur] && s.sh != 4'h0))
		else $error("no channel acquiring during conversion");
endmodule
`default_nettype wire
